// ==== cmm_pkg.sv ====
// Package with memory map, region types and stack select layout
package cmm_pkg;

  localparam int unsigned ADDR_W = 32;

  // Memory types
  typedef enum logic [1:0]
  {
    CMM_NORMAL   = 2'b00,
    CMM_DEVICE   = 2'b01,
    CMM_STRONGLY = 2'b10
  } cmm_mtype_e;

  // Access sizes
  typedef enum logic [1:0]
  {
    CMM_SZ_BYTE = 2'b00,
    CMM_SZ_HALF = 2'b01,
    CMM_SZ_WORD = 2'b10
  } cmm_size_e;

  // Region boundaries (inclusive lower bounds; PPB_LAST is an inclusive upper bound)
  localparam logic [31:0] SRAM_BASE    = 32'h2000_0000;
  localparam logic [31:0] PERIPH_BASE  = 32'h4000_0000;
  localparam logic [31:0] EXTRAM_BASE  = 32'h6000_0000;
  localparam logic [31:0] EXTDEV_BASE  = 32'ha000_0000;
  localparam logic [31:0] PPB_BASE     = 32'he000_0000;
  localparam logic [31:0] PPB_LAST     = 32'he00f_ffff;
  localparam logic [31:0] VENDOR_BASE  = 32'he010_0000;

  // Stack select control layout
  localparam int unsigned SPSEL_BIT    = 1;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

  typedef struct packed
  {
    logic [31:0] addr;
    cmm_size_e   size;
    logic        write;
    logic        fetch;
    logic        shareable;
    logic [31:0] wdata;
  } cmm_req_s;

  typedef struct packed
  {
    cmm_mtype_e mtype;
    logic       xn;
    logic       private_peripheral_bus_region;
  } cmm_region_s;

endpackage

// ==== cmm_core.sv ====
// Core memory model: region decode, ordering, buffering, stack select
`timescale 1ns/10ps
`default_nettype none

// Function
// RULE1: Stack select bit one chooses process stack
// RULE2: Handler mode reads zero, discards writes
// RULE3: Exception entry and return update register
// RULE4: After reset thread mode uses main stack
// RULE5: Software places barrier after stack change
// RULE6: Exceptions switch core into handler mode
// RULE7: Byte, halfword and word data supported
// RULE8: All accesses use little-endian byte order
// RULE9: Fixed non-relocatable 4GB address space
// RULE10: Regions carry memory type and attributes
// RULE11: Normal accesses may reorder and speculate
// RULE12: Device ordered against device, strongly-ordered; code holds device after device only when shareable matches
// RULE13: Strongly-ordered ordered against every access
// RULE14: Buffer device writes, never strongly-ordered
// RULE15: Execute-never fetch raises hard fault
// RULE16: Ordinary completion order may differ
// RULE17: Ordering table for device, strongly-ordered pairs
// RULE18: Software inserts barrier when order needed
// RULE19: Core peripherals reserved from 0xE0000000
// RULE20: Private bus strongly-ordered, execute-never, words
// RULE21: Only code and memories hold programs
// RULE22: Combinational region decode before transfer
module cmm_core
(
  // Clock and reset
  input  wire  logic             clk,
  input  wire  logic             rst_n,
  // Exception sequencing
  input  wire  logic             exc_entry,
  input  wire  logic             exc_return,
  input  wire  logic             ret_to_thread,
  input  wire  logic             ret_spsel,
  // Special register move
  input  wire  logic             ctrl_wr,
  input  wire  logic [31:0]      ctrl_wdata,
  output logic       [31:0]      ctrl_rdata,
  output logic                   handler_mode,
  output logic                   use_process_stack,
  // Barrier from instruction stream
  input  wire  logic             barrier,
  // Request from instruction stream
  input  wire  logic             req_valid,
  input  wire  cmm_pkg::cmm_req_s req,
  output logic                   req_ready,
  // Decoded attributes of the request
  output cmm_pkg::cmm_region_s   req_region,
  output logic                   hard_fault,
  // Bus side
  output logic                   bus_valid,
  output logic       [31:0]      bus_addr,
  output logic       [3:0]       bus_be,
  output logic       [31:0]      bus_wdata,
  output logic                   bus_write,
  output logic                   bus_bufferable,
  input  wire  logic             bus_ready,
  input  wire  logic             bus_done,
  input  wire  logic [31:0]      bus_rdata,
  output logic       [31:0]      rd_data,
  output logic                   rd_valid
);

  function automatic cmm_pkg::cmm_region_s decode(input logic [31:0] a);
    cmm_pkg::cmm_region_s r;
    r = '{mtype: cmm_pkg::CMM_DEVICE, xn: 1'b1, private_peripheral_bus_region: 1'b0};
    if (a < cmm_pkg::SRAM_BASE)
      r = '{mtype: cmm_pkg::CMM_NORMAL, xn: 1'b0, private_peripheral_bus_region: 1'b0}; // RULE21
    else if (a < cmm_pkg::PERIPH_BASE)
      r = '{mtype: cmm_pkg::CMM_NORMAL, xn: 1'b0, private_peripheral_bus_region: 1'b0};
    else if (a < cmm_pkg::EXTRAM_BASE)
      r = '{mtype: cmm_pkg::CMM_DEVICE, xn: 1'b1, private_peripheral_bus_region: 1'b0};
    else if (a < cmm_pkg::EXTDEV_BASE)
      r = '{mtype: cmm_pkg::CMM_NORMAL, xn: 1'b0, private_peripheral_bus_region: 1'b0};
    else if (a < cmm_pkg::PPB_BASE)
      r = '{mtype: cmm_pkg::CMM_DEVICE, xn: 1'b1, private_peripheral_bus_region: 1'b0};
    else if (a <= cmm_pkg::PPB_LAST)
      r = '{mtype: cmm_pkg::CMM_STRONGLY, xn: 1'b1, private_peripheral_bus_region: 1'b1}; // RULE19 RULE20
    return r; // RULE9 RULE10
  endfunction

  // Little-endian lane enables
  function automatic logic [3:0] lanes(input cmm_pkg::cmm_size_e s, input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (s)
      cmm_pkg::CMM_SZ_BYTE: m = 4'h1 << a;
      cmm_pkg::CMM_SZ_HALF: m = a[1] ? 4'hc : 4'h3;
      default:              m = 4'hf;
    endcase
    return m; // RULE7 RULE8
  endfunction

  logic        ctrl_spsel;
  logic        in_handler;
  logic        outstanding;
  logic        out_ordered;
  logic        out_strong;
  logic        out_share;
  logic        blocked;
  logic        illegal;
  logic [31:0] shifted;

  // Stack select and mode tracking
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_spsel <= cmm_pkg::CTRL_RESET[cmm_pkg::SPSEL_BIT]; // RULE4
      in_handler <= 1'b0;
    end
    else if (exc_entry)
    begin
      in_handler <= 1'b1; // RULE6
      ctrl_spsel <= 1'b0; // RULE3
    end
    else if (exc_return)
    begin
      in_handler <= !ret_to_thread;
      ctrl_spsel <= ret_to_thread ? ret_spsel : 1'b0; // RULE3
    end
    else if (ctrl_wr && !in_handler)
      ctrl_spsel <= ctrl_wdata[cmm_pkg::SPSEL_BIT]; // RULE1 RULE2 RULE5
  end

  always_comb
  begin
    ctrl_rdata = 32'h0000_0000;
    ctrl_rdata[cmm_pkg::SPSEL_BIT] = ctrl_spsel && !in_handler; // RULE2
  end

  assign handler_mode      = in_handler;
  assign use_process_stack = ctrl_spsel && !in_handler; // RULE1

  // Attribute decode, combinational
  assign req_region = decode(req.addr); // RULE22
  assign illegal    = req_region.private_peripheral_bus_region && (req.size != cmm_pkg::CMM_SZ_WORD); // RULE20
  assign hard_fault = req_valid && ((req.fetch && req_region.xn) || illegal); // RULE15

  // Ordering: hold a request while a conflicting one is in flight
  always_comb
  begin
    blocked = 1'b0;
    if (outstanding)
    begin
      if (barrier)
        blocked = 1'b1; // RULE18
      else if (req_region.mtype == cmm_pkg::CMM_STRONGLY || out_strong)
        blocked = 1'b1; // RULE13 RULE17
      else if (req_region.mtype == cmm_pkg::CMM_DEVICE && out_ordered)
        blocked = (req.shareable == out_share); // RULE12 RULE17
      else
        blocked = 1'b0; // RULE11 RULE16
    end
  end

  assign req_ready = bus_ready && !blocked && !hard_fault;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      outstanding <= 1'b0;
      out_ordered <= 1'b0;
      out_strong  <= 1'b0;
      out_share   <= 1'b0;
    end
    else if (req_valid && req_ready)
    begin
      outstanding <= 1'b1;
      out_ordered <= req_region.mtype != cmm_pkg::CMM_NORMAL;
      out_strong  <= req_region.mtype == cmm_pkg::CMM_STRONGLY;
      out_share   <= req.shareable;
    end
    else if (bus_done)
    begin
      outstanding <= 1'b0;
      out_ordered <= 1'b0;
      out_strong  <= 1'b0;
    end
  end

  // Bus issue, registered
  assign shifted = req.wdata << {req.addr[1:0], 3'b000};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bus_valid      <= 1'b0;
      bus_addr       <= 32'h0000_0000;
      bus_be         <= 4'h0;
      bus_wdata      <= 32'h0000_0000;
      bus_write      <= 1'b0;
      bus_bufferable <= 1'b0;
    end
    else
    begin
      bus_valid <= req_valid && req_ready;
      if (req_valid && req_ready)
      begin
        bus_addr       <= {req.addr[31:2], 2'b00};
        bus_be         <= lanes(req.size, req.addr[1:0]); // RULE8
        bus_wdata      <= shifted; // RULE8
        bus_write      <= req.write;
        bus_bufferable <= req.write && req_region.mtype != cmm_pkg::CMM_STRONGLY; // RULE14
      end
    end
  end

  // Read return, little-endian lane extract
  logic [1:0]         rd_off;
  cmm_pkg::cmm_size_e rd_size;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_off  <= 2'b00;
      rd_size <= cmm_pkg::CMM_SZ_WORD;
    end
    else if (req_valid && req_ready)
    begin
      rd_off  <= req.addr[1:0];
      rd_size <= req.size;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data  <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= bus_done && !bus_write;
      if (bus_done && !bus_write)
      begin
        case (rd_size)
          cmm_pkg::CMM_SZ_BYTE: rd_data <= {24'h000000, bus_rdata[{rd_off, 3'b000} +: 8]}; // RULE7
          cmm_pkg::CMM_SZ_HALF: rd_data <= {16'h0000, bus_rdata[{rd_off[1], 4'h0} +: 16]};
          default:              rd_data <= bus_rdata;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== cmm_monitor.sv ====
// Checker on the core memory model ports
`timescale 1ns/10ps
`default_nettype none
module cmm_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic exc_entry,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic hard_fault,
  input wire logic handler_mode,
  input wire logic use_process_stack,
  input wire logic bus_valid,
  input wire logic bus_bufferable,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] ctrl_rdata,
  input wire cmm_pkg::cmm_req_s req,
  input wire cmm_pkg::cmm_region_s req_region
);
  logic [1:0] lane_q;
  always_ff @(posedge clk)
    lane_q <= req.addr[1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  a_handler_reads_zero: assert property (handler_mode |-> ctrl_rdata == 32'h0) else $error("select seen");
  a_sel_picks_stack: assert property (use_process_stack == ctrl_rdata[1]) else $error("stack");
  a_reset_main: assert property ($rose(rst_n) |-> !use_process_stack && !handler_mode) else $error("reset");
  a_entry_handler: assert property (exc_entry |=> handler_mode && !use_process_stack) else $error("entry");
  a_xn_fetch_fault: assert property (req_valid && req.fetch && req_region.xn |-> hard_fault && !req_ready)
    else $error("xn fetch");
  a_ppb_attrs: assert property (req.addr[31:20] == 12'he00 |-> req_region == 4'b1011) else $error("ppb");
  a_so_unbuffered: assert property (bus_valid && bus_addr[31:20] == 12'he00 |-> !bus_bufferable)
    else $error("buffered");
  a_take_issues: assert property (s_take |=> bus_valid) else $error("no issue");
  a_byte_lane: assert property (s_take ##0 req.size == cmm_pkg::CMM_SZ_BYTE |=> bus_be == 4'h1 << lane_q)
    else $error("lane");
endmodule
`default_nettype wire

// ==== cmm_bus_mem.sv ====
// Bus partner model answering with a fixed word
`timescale 1ns/10ps
`default_nettype none
module cmm_bus_mem
(
  // Clock, reset and pace
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  // Bus
  input wire logic bus_valid,
  output logic bus_ready,
  output logic bus_done,
  output logic [31:0] bus_rdata
);
  logic [3:0] cnt;
  assign bus_ready = 1'b1;
  always_ff @(posedge clk)
    if (!rst_n)
      cnt <= 4'h0;
    else if (bus_valid)
      cnt <= slow ? 4'h6 : 4'h1;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  assign bus_done = cnt == 4'h1;
  // Inverted word outside the answer cycle
  assign bus_rdata = bus_done ? 32'h4433_2211 : 32'hbbcc_ddee;
endmodule
`default_nettype wire

// ==== cmm_core_tb.sv ====
// Bench for the core memory model
`timescale 1ns/10ps
`default_nettype none
module cmm_core_tb;
  typedef struct packed
  {
    logic [31:0] a;
    logic [1:0]  s;
    logic [2:0]  r;
    logic [31:0] d;
  } cmm_row_s;
  logic clk = 0, rst_n = 0, slow = 0, exc_entry = 0, exc_return = 0, ret_to_thread = 1, ret_spsel = 1;
  logic ctrl_wr = 0, barrier = 0, req_valid = 0, handler_mode, use_process_stack, req_ready, hard_fault;
  logic bus_valid, bus_write, bus_bufferable, bus_ready, bus_done, rd_valid;
  logic [31:0] ctrl_wdata = 32'hffff_ffff, ctrl_rdata, bus_addr, bus_wdata, bus_rdata, rd_data;
  logic [3:0] bus_be;
  cmm_pkg::cmm_req_s req = '0;
  cmm_pkg::cmm_region_s req_region, rg;
  int n_fail = 0, cmp_count = 0;
  cmm_row_s rows [6] = '{'{32'h0000_0003, 2'h0, 3'h0, 32'h44}, '{32'h2000_0002, 2'h1, 3'h0, 32'h4433},
    '{32'h4000_0001, 2'h0, 3'h3, 32'h22}, '{32'h6000_0000, 2'h2, 3'h0, 32'h4433_2211},
    '{32'he000_0000, 2'h2, 3'h5, 32'h4433_2211}, '{32'he010_0002, 2'h1, 3'h3, 32'h4433}};
  always #5 clk = ~clk;
  cmm_core dut (.*);
  cmm_bus_mem mem (.clk, .rst_n, .slow, .bus_valid, .bus_ready, .bus_done, .bus_rdata);
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick();
    s = 0;
  endtask
  task automatic ask(input logic [31:0] a, input logic [1:0] s, input logic w, f);
    req = '{a, cmm_pkg::cmm_size_e'(s), w, f, 1'b0, 32'h0000_a5a5};
    req_valid = 1;
    #1;
  endtask
  task automatic go(input logic [31:0] a, input logic [1:0] s, input logic w, f);
    int i;
    ask(a, s, w, f);
    rg = req_region;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) tick();
    tick();
    req_valid = 0;
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    $display("unexpected at %0t: watchdog", $time);
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    chk(ctrl_rdata, 32'h0);
    foreach (rows[k])
    begin
      go(rows[k].a, rows[k].s, 1'b0, 1'b0);
      chk({rg.mtype, rg.xn}, rows[k].r);
      chk(bus_addr, rows[k].a & 32'hffff_fffc);
      repeat (2) tick();
      chk(rd_data, rows[k].d);
      chk({31'h0, rd_valid}, 32'h1);
    end
    $display("region rows done");
    pulse(ctrl_wr);
    chk(ctrl_rdata, 32'h2);
    pulse(exc_entry);
    pulse(ctrl_wr);
    chk({31'h0, handler_mode}, 32'h1);
    chk(ctrl_rdata, 32'h0);
    pulse(exc_return);
    chk({31'h0, handler_mode}, 32'h0);
    chk(ctrl_rdata, 32'h2);
    $display("stack select done");
    ask(32'h4000_0000, 2'h2, 1'b0, 1'b1);
    tick();
    chk({hard_fault, req_ready}, 32'h2);
    ask(32'he000_0000, 2'h0, 1'b1, 1'b0);
    chk(hard_fault, 32'h1);
    req_valid = 0;
    go(32'h2000_0001, 2'h0, 1'b1, 1'b0);
    chk({bus_be, bus_wdata[15:8]}, 32'h2a5);
    chk({31'h0, bus_write}, 32'h1);
    slow = 1;
    go(32'he000_0000, 2'h2, 1'b1, 1'b0);
    ask(32'h2000_0000, 2'h2, 1'b0, 1'b0);
    chk(req_ready, 32'h0);
    go(32'h4000_0000, 2'h2, 1'b1, 1'b0);
    chk(bus_bufferable, 32'h1);
    ask(32'h4000_0004, 2'h2, 1'b0, 1'b0);
    chk(req_ready, 32'h0);
    ask(32'h2000_0000, 2'h2, 1'b0, 1'b0);
    chk(req_ready, 32'h1);
    barrier = 1;
    #1;
    chk(req_ready, 32'h0);
    barrier = 0;
    go(32'he000_0004, 2'h2, 1'b1, 1'b0);
    chk(bus_bufferable, 32'h0);
    $display("ordering done");
    repeat (8) tick();
    summarize();
  end
endmodule
bind cmm_core cmm_monitor mon (.*);
`default_nettype wire
